// *** core/tlic_pkg.sv ***
// Package with register addresses, field positions and vector table for the interrupt controller.
`default_nettype none
package tlic_pkg;
    // ------------------------------------------------------------------
    // Register addresses and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] TLIC_ADDR_ENABLE_PRI = 8'ha8;
    localparam logic [7:0] TLIC_ADDR_ENABLE_SEC = 8'ha9;
    localparam logic [7:0] TLIC_ADDR_LEVEL_SEL  = 8'hb8;
    localparam logic [7:0] TLIC_RESET_VALUE     = 8'h00;
    localparam logic [7:0] TLIC_SEC_IMPL_MASK   = 8'h03;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TLIC_GLOBAL_BIT = 7;
    localparam int TLIC_NUM_SRC    = 9;

    // Source index in polling order, first (0) to last (8).
    localparam int TLIC_SRC_SUPPLY = 0;
    localparam int TLIC_SRC_EXT0   = 1;
    localparam int TLIC_SRC_CONV   = 2;
    localparam int TLIC_SRC_TMR0   = 3;
    localparam int TLIC_SRC_EXT1   = 4;
    localparam int TLIC_SRC_TMR1   = 5;
    localparam int TLIC_SRC_SBUS   = 6;
    localparam int TLIC_SRC_UART   = 7;
    localparam int TLIC_SRC_TMR2   = 8;

    typedef logic [TLIC_NUM_SRC-1:0] tlic_src_vec_t;
    typedef logic [3:0]              tlic_src_idx_t;
    typedef logic [15:0]             tlic_vector_t;

    // Vector address for each source, indexed by polling position.
    localparam tlic_vector_t TLIC_VECTORS [TLIC_NUM_SRC] = '{
        16'h0043, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
        16'h001b, 16'h003b, 16'h0023, 16'h002b};
endpackage : tlic_pkg
`default_nettype wire

// *** core/tlic_sync3.sv ***
// Three-stage synchroniser with agreement filter for an asynchronous request pin.
`default_nettype none
module tlic_sync3 (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic pin_in,
    output var  logic level_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Shifts the pin through three flops; the first is read only by the second.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accepts a change only once the second and third stages agree.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            level_out <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_out <= s3_q;
        end
    end
endmodule : tlic_sync3 // tlic_sync3
`default_nettype wire

// *** core/tlic_picker.sv ***
// Fixed-order picker: chooses the first pending source in polling order.
`default_nettype none
module tlic_picker
    import tlic_pkg::*;
(
    input  wire tlic_pkg::tlic_src_vec_t pending,
    output var  logic                    found,
    output var  tlic_pkg::tlic_src_idx_t winner
);
    // Scans from the last position down so the lowest index ends up chosen.
    always_comb begin
        found  = 1'b0;
        winner = '0;
        for (int i = TLIC_NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                found  = 1'b1;
                winner = tlic_src_idx_t'(i);
            end
        end
    end
endmodule : tlic_picker // tlic_picker
`default_nettype wire

// *** core/tlic_top.sv ***
// Two-level interrupt controller: enable and level registers, arbitration and vectoring.
//
// Overview of operation
// - Global enable bit 7 gates every request.
// - Primary enable bits 6..0 enable seven sources.
// - Secondary enable: bit1 supply, bit0 serial bus.
// - Level register picks high or low per source; supply has no bit and stays low.
// - High-level request preempts low-level routine.
// - Simultaneous mixed levels: high level served first.
// - Same-level request never preempts running routine.
// - Equal-level ties resolved in fixed polling order.
// - Core pushes PC, then loads winning vector.
// - Each source has its fixed vector address.
// - UART request is rx OR tx, never cleared.
`default_nettype none
module tlic_top
    import tlic_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    // Special function register port from the core.
    input  wire logic [7:0]            sfr_addr,
    input  wire logic                  sfr_wr,
    input  wire logic [7:0]            sfr_wdata,
    input  wire logic                  sfr_rd,
    output var  logic [7:0]            sfr_rdata,
    output var  logic                  sfr_hit,
    // Request sources; external lines come from pins.
    input  wire logic                  supply_watch_req,
    input  wire logic                  ext_zero_req,
    input  wire logic                  converter_req,
    input  wire logic                  timer_zero_overflow,
    input  wire logic                  ext_one_req,
    input  wire logic                  timer_one_overflow,
    input  wire logic                  two_wire_req,
    input  wire logic                  four_wire_req,
    input  wire logic                  rx_done_flag,
    input  wire logic                  tx_done_flag,
    input  wire logic                  timer_two_overflow,
    input  wire logic                  timer_two_external_flag,
    // Core handshake.
    output logic                       irq_request,
    output var  tlic_pkg::tlic_vector_t irq_vector,
    input  wire logic                  irq_accept,
    input  wire logic                  reti_done,
    output var  logic                  push_pc,
    output var  logic                  load_pc,
    output var  logic                  in_service_high,
    output var  logic                  in_service_low
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]    irq_enable_primary_q;
    logic [1:0]    irq_enable_secondary_q;
    logic [7:0]    irq_level_select_q;
    logic          ext_zero_sync;
    logic          ext_one_sync;
    tlic_src_vec_t raw_req;
    tlic_src_vec_t src_enable;
    tlic_src_vec_t src_high;
    tlic_src_vec_t pend_high;
    tlic_src_vec_t pend_low;
    logic          found_high;
    logic          found_low;
    tlic_src_idx_t win_high;
    tlic_src_idx_t win_low;
    logic          active_high_q;
    logic          active_low_q;
    logic          take_high;
    logic          take_low;
    tlic_src_idx_t chosen;
    logic          vector_phase_q;
    tlic_vector_t  vector_hold_q;
    logic [2:0]    reg_sel;

    // ------------------------------------------------------------------
    // Request gathering
    // ------------------------------------------------------------------

    // External lines arrive from pins and are synchronised first.
    // The filter adds four cycles of latency; a pulse shorter than two cycles
    // on a pin may be lost, so the external lines are meant to be levels.
    tlic_sync3 u_sync_ext0 (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .pin_in    (ext_zero_req),
        .level_out (ext_zero_sync)
    );

    tlic_sync3 u_sync_ext1 (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .pin_in    (ext_one_req),
        .level_out (ext_one_sync)
    );

    // Combined requests in polling order; flags are only read, never cleared here.
    // Paired sources are ORed, so either flag of a pair raises the one request.
    always_comb begin
        raw_req                 = '0;
        raw_req[TLIC_SRC_SUPPLY] = supply_watch_req;
        raw_req[TLIC_SRC_EXT0]   = ext_zero_sync;
        raw_req[TLIC_SRC_CONV]   = converter_req;
        raw_req[TLIC_SRC_TMR0]   = timer_zero_overflow;
        raw_req[TLIC_SRC_EXT1]   = ext_one_sync;
        raw_req[TLIC_SRC_TMR1]   = timer_one_overflow;
        raw_req[TLIC_SRC_SBUS]   = two_wire_req | four_wire_req;
        raw_req[TLIC_SRC_UART]   = rx_done_flag | tx_done_flag;
        raw_req[TLIC_SRC_TMR2]   = timer_two_overflow | timer_two_external_flag;
    end

    // Per-source enable, gated by the global bit.
    always_comb begin
        src_enable                  = '0;
        src_enable[TLIC_SRC_SUPPLY] = irq_enable_secondary_q[1];
        src_enable[TLIC_SRC_SBUS]   = irq_enable_secondary_q[0];
        src_enable[TLIC_SRC_CONV]   = irq_enable_primary_q[6];
        src_enable[TLIC_SRC_TMR2]   = irq_enable_primary_q[5];
        src_enable[TLIC_SRC_UART]   = irq_enable_primary_q[4];
        src_enable[TLIC_SRC_TMR1]   = irq_enable_primary_q[3];
        src_enable[TLIC_SRC_EXT1]   = irq_enable_primary_q[2];
        src_enable[TLIC_SRC_TMR0]   = irq_enable_primary_q[1];
        src_enable[TLIC_SRC_EXT0]   = irq_enable_primary_q[0];
        if (!irq_enable_primary_q[TLIC_GLOBAL_BIT]) begin
            src_enable = '0;
        end
    end

    // Level per source; the supply monitor has no level bit and stays low.
    // It therefore can never preempt a running routine, but it still wins
    // every tie at the low level.
    always_comb begin
        src_high                  = '0;
        src_high[TLIC_SRC_SBUS]   = irq_level_select_q[7];
        src_high[TLIC_SRC_CONV]   = irq_level_select_q[6];
        src_high[TLIC_SRC_TMR2]   = irq_level_select_q[5];
        src_high[TLIC_SRC_UART]   = irq_level_select_q[4];
        src_high[TLIC_SRC_TMR1]   = irq_level_select_q[3];
        src_high[TLIC_SRC_EXT1]   = irq_level_select_q[2];
        src_high[TLIC_SRC_TMR0]   = irq_level_select_q[1];
        src_high[TLIC_SRC_EXT0]   = irq_level_select_q[0];
    end

    // Pending requests split by level, each already gated by its enables.
    assign pend_high = raw_req & src_enable & src_high;
    assign pend_low  = raw_req & src_enable & ~src_high;

    // ------------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------------

    // One picker per level; both run every cycle and the level logic below chooses.
    tlic_picker u_pick_high (
        .pending (pend_high),
        .found   (found_high),
        .winner  (win_high)
    );

    tlic_picker u_pick_low (
        .pending (pend_low),
        .found   (found_low),
        .winner  (win_low)
    );

    // High wins over low; a level already in service blocks its own level.
    // A low request also waits for a running high routine; it may only start
    // once both levels are free.
    always_comb begin
        take_high = found_high && !active_high_q;
        take_low  = found_low && !active_high_q && !active_low_q;
        if (take_high) begin
            chosen = win_high;
        end else begin
            chosen = win_low;
        end
    end

    // Request held off while a vector sequence is in progress.
    assign irq_request = (take_high || take_low) && !vector_phase_q;
    assign irq_vector  = vector_hold_q;

    // ------------------------------------------------------------------
    // Vector presentation
    // ------------------------------------------------------------------

    // Keeps the vector of the current candidate ready in a flop for the core.
    // It is frozen from accept to load, so a candidate that turns up while the
    // core is pushing cannot change the address that it is about to load.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            vector_hold_q <= '0;
        end else if (!vector_phase_q) begin
            vector_hold_q <= TLIC_VECTORS[chosen];
        end
    end

    // Accept issues push in the first cycle, then load in the next.
    // The offer is withdrawn for these two cycles so that a second accept
    // cannot land before the first entry is complete.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            vector_phase_q <= 1'b0;
            push_pc        <= 1'b0;
            load_pc        <= 1'b0;
        end else begin
            push_pc        <= irq_accept && irq_request;
            load_pc        <= push_pc;
            vector_phase_q <= (irq_accept && irq_request) || push_pc;
        end
    end

    // ------------------------------------------------------------------
    // In-service tracking
    // ------------------------------------------------------------------

    // Sets the level on accept; a return releases the highest level active.
    // Two levels need one flag each: a high routine may nest on a low one,
    // never the other way round, and never on a routine of its own level.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            active_high_q <= 1'b0;
            active_low_q  <= 1'b0;
        end else begin
            if (irq_accept && irq_request && take_high) begin
                active_high_q <= 1'b1;
            end else if (reti_done && active_high_q) begin
                active_high_q <= 1'b0;
            end
            if (irq_accept && irq_request && !take_high) begin
                active_low_q <= 1'b1;
            end else if (reti_done && !active_high_q) begin
                active_low_q <= 1'b0;
            end
        end
    end

    assign in_service_high = active_high_q;
    assign in_service_low  = active_low_q;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------

    // Turns a register address into a one-hot select: bit 0 primary enable,
    // bit 1 secondary enable, bit 2 level select; an unmapped address gives zero.
    // Write, read and the hit flag all share it, so they can never disagree.
    function automatic logic [2:0] decode_reg(input logic [7:0] addr);
        logic [2:0] sel;
        sel = 3'h0;
        if (addr == TLIC_ADDR_ENABLE_PRI) begin
            sel[0] = 1'b1;
        end
        if (addr == TLIC_ADDR_ENABLE_SEC) begin
            sel[1] = 1'b1;
        end
        if (addr == TLIC_ADDR_LEVEL_SEL) begin
            sel[2] = 1'b1;
        end
        return sel;
    endfunction

    // Select of the register that the core currently addresses.
    assign reg_sel = decode_reg(sfr_addr);

    // Writes update the addressed register; reserved secondary bits are dropped.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_enable_primary_q   <= TLIC_RESET_VALUE;
            irq_enable_secondary_q <= TLIC_RESET_VALUE[1:0];
            irq_level_select_q     <= TLIC_RESET_VALUE;
        end else if (sfr_wr) begin
            if (reg_sel[0]) begin
                irq_enable_primary_q <= sfr_wdata;
            end
            if (reg_sel[1]) begin
                irq_enable_secondary_q <= sfr_wdata[1:0];
            end
            if (reg_sel[2]) begin
                irq_level_select_q <= sfr_wdata;
            end
        end
    end

    // Read data registered; reserved bits and unmapped addresses read zero.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sfr_rdata <= '0;
        end else if (sfr_rd) begin
            unique case (reg_sel)
                3'h1:    sfr_rdata <= irq_enable_primary_q;
                3'h2:    sfr_rdata <= {6'h00, irq_enable_secondary_q};
                3'h4:    sfr_rdata <= irq_level_select_q;
                default: sfr_rdata <= '0;
            endcase
        end
    end

    // Tells the core the address belongs to this block.
    assign sfr_hit = |reg_sel;
endmodule : tlic_top // tlic_top
`default_nettype wire

// *** verif/tlic_checker.sv ***
// Concurrent checks on the ports of the interrupt controller top.
`default_nettype none
module tlic_checker
    import tlic_pkg::*;
(
    input wire logic                   sys_clk,
    input wire logic                   srst,
    input wire logic [7:0]             sfr_addr,
    input wire logic                   sfr_wr,
    input wire logic [7:0]             sfr_wdata,
    input wire logic                   sfr_rd,
    input wire logic [7:0]             sfr_rdata,
    input wire logic                   irq_request,
    input wire tlic_pkg::tlic_vector_t irq_vector,
    input wire logic                   irq_accept,
    input wire logic                   reti_done,
    input wire logic                   push_pc,
    input wire logic                   load_pc,
    input wire logic                   in_service_high
);
    timeunit 1ns;
    timeprecision 100ps;
    logic glob_q;
    logic take;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // A request is taken when the core accepts while one is offered.
    assign take = irq_accept && irq_request;
    // Mirrors the global enable bit, which acts from the edge of its write.
    always_ff @(posedge sys_clk) begin
        if (srst) glob_q <= 1'h0;
        else if (sfr_wr && sfr_addr == 8'ha8) glob_q <= sfr_wdata[7];
    end
    property p_gate; !glob_q |-> !irq_request; endproperty
    a_gate: assert property (p_gate) else $error("offer while globally off");
    property p_sec; sfr_rd && sfr_addr == 8'ha9 |=> sfr_rdata[7:2] == 6'h00; endproperty
    a_sec: assert property (p_sec) else $error("reserved bits read as one");
    property p_unmap;
        sfr_rd && !(sfr_addr inside {8'ha8, 8'ha9, 8'hb8}) |=> sfr_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_push; take |=> push_pc ##1 load_pc; endproperty
    a_push: assert property (p_push) else $error("push then load missing");
    property p_cause; push_pc |-> $past(take); endproperty
    a_cause: assert property (p_cause) else $error("push without accept");
    property p_gap; take |=> !irq_request [*2]; endproperty
    a_gap: assert property (p_gap) else $error("offer during push and load");
    property p_vec;
        load_pc |-> irq_vector inside {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
                                       16'h002b, 16'h0033, 16'h003b, 16'h0043};
    endproperty
    a_vec: assert property (p_vec) else $error("vector not in table");
    property p_high; in_service_high |-> !irq_request; endproperty
    a_high: assert property (p_high) else $error("offer over high routine");
    property p_reti; reti_done && in_service_high |=> !in_service_high; endproperty
    a_reti: assert property (p_reti) else $error("high level not released");
endmodule // tlic_checker
`default_nettype wire

// *** verif/tlic_core_model.sv ***
// Behavioural model of the processor core side of the interrupt handshake.
`default_nettype none
module tlic_core_model
    import tlic_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    input  wire logic                   irq_request,
    input  wire tlic_pkg::tlic_vector_t irq_vector,
    input  wire logic                   push_pc,
    input  wire logic                   load_pc,
    input  wire logic [3:0]             lag,
    output var  logic                   irq_accept,
    output var  tlic_pkg::tlic_vector_t got_vec,
    output var  logic [7:0]             got_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] wait_q;
    logic       pushed_q;
    // Accepts once the offer has stood lag cycles, so the vector has settled.
    always_ff @(posedge sys_clk) begin
        if (srst || !irq_request || irq_accept) wait_q <= 4'h0;
        else if (wait_q != 4'hf) wait_q <= wait_q + 4'h1;
        irq_accept <= !srst && irq_request && !irq_accept && wait_q >= lag;
    end
    // Loads the vector at the load pulse that follows a push, and counts entries.
    always_ff @(posedge sys_clk) begin
        pushed_q <= !srst && push_pc;
        if (srst) got_cnt <= 8'h00;
        else if (load_pc && pushed_q) begin
            got_cnt <= got_cnt + 8'h01;
            got_vec <= irq_vector;
        end
    end
endmodule // tlic_core_model
`default_nettype wire

// *** verif/tlic_top_tb_top.sv ***
// Self-checking testbench for the two-level interrupt controller.
`default_nettype none
module tlic_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic                   sys_clk = 1'h0;
    logic                   srst, sfr_wr, sfr_rd, irq_request, irq_accept, reti_done;
    logic                   push_pc, load_pc, in_service_high, in_service_low, sfr_hit;
    logic [7:0]             sfr_addr, sfr_wdata, sfr_rdata, got_cnt;
    logic [11:0]            rq;
    logic [3:0]             lag;
    tlic_pkg::tlic_vector_t irq_vector, got_vec;
    int                     num_errors = 0;
    int                     checks = 0;
    int                     cyc = 0;
    logic [7:0]  pe_t [13] = '{8'h80, 8'h81, 8'hc0, 8'h82, 8'h84, 8'h88, 8'h80, 8'h90,
                               8'ha0, 8'h90, 8'h90, 8'ha0, 8'h80};
    logic [7:0]  se_t [13] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00,
                               8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    logic [15:0] ev_t [13] = '{16'h0043, 16'h0003, 16'h0033, 16'h000b, 16'h0013, 16'h001b,
                               16'h003b, 16'h0023, 16'h002b, 16'h0023, 16'h0023, 16'h002b,
                               16'h003b};
    logic [11:0] rq_t [4]  = '{12'h100, 12'h200, 12'h800, 12'h080};
    logic [11:0] sm_t [9]  = '{12'h001, 12'h002, 12'h004, 12'h008, 12'h010, 12'h020,
                               12'h0c0, 12'h300, 12'hc00};
    tlic_top dut (
        .sys_clk, .srst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .sfr_hit,
        .supply_watch_req(rq[0]), .ext_zero_req(rq[1]), .converter_req(rq[2]),
        .timer_zero_overflow(rq[3]), .ext_one_req(rq[4]), .timer_one_overflow(rq[5]),
        .two_wire_req(rq[6]), .four_wire_req(rq[7]), .rx_done_flag(rq[8]),
        .tx_done_flag(rq[9]), .timer_two_overflow(rq[10]), .timer_two_external_flag(rq[11]),
        .irq_request, .irq_vector, .irq_accept, .reti_done, .push_pc, .load_pc,
        .in_service_high, .in_service_low);
    tlic_core_model u_core (.sys_clk, .srst, .irq_request, .irq_vector, .push_pc,
        .load_pc, .lag, .irq_accept, .got_vec, .got_cnt);
    // Free-running core clock and a cycle ceiling against hangs.
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end
    // Shared helpers for comparing, stepping and register access.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'h1;
        tick();
        sfr_wr = 1'h0;
        tick();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sfr_addr = a;
        sfr_rd = 1'h1;
        tick();
        sfr_rd = 1'h0;
        chk(sfr_rdata, e);
        tick();
    endtask
    task automatic reti();
        reti_done = 1'h1;
        tick();
        reti_done = 1'h0;
        tick();
    endtask
    // Waits a bounded time for the core to enter a routine, then checks its vector.
    task automatic srv(input logic [15:0] ev);
        logic [7:0] c;
        int n;
        c = got_cnt;
        n = 0;
        while (got_cnt === c && n < 40) begin
            tick();
            n++;
        end
        chk(got_cnt, 8'(c + 8'h01));
        chk(got_vec, ev);
    endtask
    // Scenarios.
    task automatic s_regs();
        rd(8'ha8, 8'h00); rd(8'ha9, 8'h00); rd(8'hb8, 8'h00);
        wr(8'ha9, 8'hff); rd(8'ha9, 8'h03);
        chk(sfr_hit, 1'h1);
        wr(8'hb8, 8'h5a); rd(8'hb8, 8'h5a);
        chk(sfr_hit, 1'h1);
        wr(8'h42, 8'hff); rd(8'h42, 8'h00);
        chk(sfr_hit, 1'h0);
        rd(8'ha8, 8'h00);
        chk(sfr_hit, 1'h1);
    endtask
    task automatic s_glob();
        wr(8'ha8, 8'h7f);
        rq = 12'hfff;
        repeat (10) tick();
        chk(irq_request, 1'h0);
        wr(8'ha8, 8'hff);
        srv(16'h0033);
        rq = 12'h000;
        repeat (6) tick();
        reti();
    endtask
    task automatic s_enables();
        for (int i = 0; i < 13; i++) begin
            wr(8'ha8, pe_t[i]);
            wr(8'ha9, se_t[i]);
            rq = (i < 9) ? 12'hfff : rq_t[i - 9];
            srv(ev_t[i]);
            rq = 12'h000;
            repeat (6) tick();
            reti();
        end
    endtask
    task automatic s_order();
        logic [7:0] c;
        wr(8'ha8, 8'hff); wr(8'ha9, 8'h03); wr(8'hb8, 8'h00);
        rq = 12'hfff;
        for (int k = 0; k < 9; k++) begin
            srv(ev_t[k]);
            rq = rq & ~sm_t[k];
            c = got_cnt;
            repeat (6) tick();
            chk(got_cnt, c);
            reti();
        end
    endtask
    task automatic s_levels();
        logic [7:0] c;
        wr(8'hb8, 8'h02); wr(8'ha9, 8'h00); wr(8'ha8, 8'hc2);
        lag = 4'h5;
        rq = 12'h00c;
        srv(16'h000b);
        chk(in_service_high, 1'h1);
        c = got_cnt;
        repeat (10) tick();
        chk(got_cnt, c);
        rq = 12'h004;
        repeat (2) tick();
        reti();
        srv(16'h0033);
        rq = 12'h00c;
        srv(16'h000b);
        chk(in_service_low, 1'h1);
        rq = 12'h000;
        repeat (2) tick();
        reti();
        chk(in_service_high, 1'h0);
        chk(in_service_low, 1'h1);
        reti();
        chk(in_service_low, 1'h0);
        lag = 4'h1;
    endtask
    task automatic complete_run();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Main sequence: reset for eight cycles, then every scenario in turn.
    initial begin
        srst = 1'h1; sfr_addr = 8'h00; sfr_wdata = 8'h00; sfr_wr = 1'h0; sfr_rd = 1'h0;
        rq = 12'h000; reti_done = 1'h0; lag = 4'h1;
        repeat (8) @(posedge sys_clk);
        #1;
        srst = 1'h0;
        s_regs(); s_glob(); s_enables(); s_order(); s_levels();
        complete_run();
    end
endmodule // tlic_top_tb_top
bind tlic_top tlic_checker u_chk (.sys_clk, .srst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
    .sfr_rdata, .irq_request, .irq_vector, .irq_accept, .reti_done, .push_pc, .load_pc,
    .in_service_high);
`default_nettype wire
